// >>> verilog/msi_ctrl.sv
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "msi_params.svh"
module msi_ctrl
   import msi_pkg::*;
#(
   parameter int      NCH         = 2,
   parameter int      SEL_TIMEOUT = `MSI_SEL_TIMEOUT_CYC,
   parameter int      HOLD_CYC    = `MSI_HOLD_CYC,
   parameter int      DEB_CYC     = `MSI_DEB_CYC,
   parameter int      FLASH_CYC   = `MSI_FLASH_CYC,
   parameter int      ACT_CYC     = `MSI_ACT_CYC,
   parameter bit      SHORT_RANGE = 1'b1,
   parameter bit [7:0] LONG_RATE  = 8'h01
) (
   // Clock, reset, enable
   input  wire logic                clk,
   input  wire logic                nrst,
   input  wire logic                ce,
   // Avalon-MM slave
   input  wire logic [7:0]          avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [31:0]         avs_writedata,
   output logic      [31:0]         avs_readdata,
   output logic                     avs_waitrequest,
   // Front panel inputs
   input  wire logic                btn_raw,
   input  wire logic                supply_ok,
   input  wire logic                frame_tx,
   input  wire logic                frame_rx,
   input  wire logic [3:0]          rssi_level,
   input  wire logic [NCH-1:0]      din,
   input  wire logic [NCH-1:0]      peer_din,
   // Front panel outputs
   output logic      [2:0]          mode_led,
   output logic      [7:0]          rssi_led,
   output logic                     act_led,
   output logic                     pwr_led,
   output logic      [NCH-1:0]      din_led,
   output logic      [NCH-1:0]      relay_led,
   output logic      [NCH-1:0]      relay_out,
   output logic      [NCH-1:0]      peer_dout
);
   initial begin
      if (NCH < 1 || NCH > 8) $error("NCH must be 1..8");
      if (SEL_TIMEOUT < 1 || HOLD_CYC < 1 || FLASH_CYC < 1 || ACT_CYC < 1)
         $error("Timing counts must be at least 1");
   end

   msi_btn_if btn ();

   msi_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
      .clk     (clk),
      .nrst    (nrst),
      .ce      (ce),
      .btn_raw (btn_raw),
      .btn     (btn.src)
   );

   typedef struct packed {
      msi_state_e       fsm;
      msi_mode_e        mode;
      msi_mode_e        cand;
      logic [31:0]      tmr;
      logic [31:0]      flash_cnt;
      logic             flash;
      logic [2:0]       ack_n;
      logic [31:0]      act_cnt;
      msi_cfg_s         cfg;
      logic             comfail;
      logic [15:0]      ain0;
      logic [15:0]      ain1;
      logic [11:0]      aout0;
      logic [11:0]      aout1;
      logic [7:0]       range;
      logic [31:0]      pulse0;
      logic [31:0]      pulse1;
      logic [NCH-1:0]   relay;
      logic [NCH-1:0]   din_q;
      logic [2:0]       mode_led;
      logic [7:0]       rssi_led;
      logic             act_led;
      logic             pwr_led;
      logic [31:0]      rdata;
      logic             ack;
   } msi_ctrl_s;

   msi_ctrl_s st;
   msi_ctrl_s next_st;

   function automatic msi_mode_e next_mode(input msi_mode_e m);
      case (m)
         MSI_MODE_FIELDBUS: next_mode = MSI_MODE_PEER_MST;
         MSI_MODE_PEER_MST: next_mode = MSI_MODE_PEER_SLV;
         MSI_MODE_PEER_SLV: next_mode = MSI_MODE_FIELDBUS;
         default:           next_mode = MSI_MODE_FIELDBUS;
      endcase
   endfunction

   function automatic msi_cfg_s defaults(input msi_mode_e m, input logic [7:0] rate);
      msi_cfg_s c;
      c.id            = `MSI_DEF_ID;
      c.retry         = `MSI_DEF_RETRY;
      c.enc           = 1'b0;
      c.addr          = `MSI_DEF_ADDR;
      c.slave_timeout = (m == MSI_MODE_PEER_MST) ? 8'd0 : `MSI_DEF_TIMEOUT_S;
      c.rate          = rate;
      return c;
   endfunction

   // Bar graph: level 0..8 fills from the bottom
   function automatic logic [7:0] bar(input logic [3:0] lvl);
      logic [7:0] b;
      b = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (lvl > 4'(i)) b[i] = 1'b1;
      end
      return b;
   endfunction

   logic [7:0] def_rate;
   assign def_rate = SHORT_RANGE ? `MSI_RATE_FIXED : LONG_RATE;

   logic pulse_en;
   logic [NCH-1:0] din_rise;
   assign pulse_en = (st.mode == MSI_MODE_FIELDBUS);
   assign din_rise = din & ~st.din_q;

   always_comb begin
      next_st       = st;
      next_st.ack   = 1'b0;
      next_st.din_q = din;

      // Blink base
      if (st.flash_cnt >= 32'(FLASH_CYC - 1)) begin
         next_st.flash_cnt = 32'h0000_0000;
         next_st.flash     = ~st.flash;
      end else begin
         next_st.flash_cnt = st.flash_cnt + 32'h0000_0001;
      end

      case (st.fsm)
         MSI_ST_RUN: begin
            next_st.tmr = 32'h0000_0000;
            if (btn.press) begin
               next_st.fsm = MSI_ST_HOLD;
            end
         end
         MSI_ST_HOLD: begin
            if (!btn.level) begin
               next_st.fsm = MSI_ST_RUN;
            end else if (st.tmr >= 32'(HOLD_CYC - 1)) begin
               next_st.fsm   = MSI_ST_ACK;
               next_st.tmr   = 32'h0000_0000;
               next_st.ack_n = 3'(`MSI_ACK_FLASHES);
               next_st.cand  = st.mode;
               // Restart blink so the first all-lamp flash is a full one
               next_st.flash_cnt = 32'h0000_0000;
               next_st.flash     = 1'b0;
            end else begin
               next_st.tmr = st.tmr + 32'h0000_0001;
            end
         end
         MSI_ST_ACK: begin
            // Ack flashes run before candidate display; the held press is not an advance
            if (st.flash_cnt >= 32'(FLASH_CYC - 1) && st.flash) begin
               next_st.ack_n = st.ack_n - 3'd1;
               if (st.ack_n == 3'd1) begin
                  next_st.fsm = MSI_ST_SEL;
                  next_st.tmr = 32'h0000_0000;
               end
            end
         end
         MSI_ST_SEL: begin
            if (btn.press) begin
               next_st.cand = next_mode(st.cand);
               next_st.tmr  = 32'h0000_0000;
            end else if (btn.level) begin
               next_st.tmr = 32'h0000_0000;
            end else if (st.tmr >= 32'(SEL_TIMEOUT - 1)) begin
               next_st.fsm  = MSI_ST_RUN;
               next_st.mode = st.cand;
               if (st.cand != st.mode) begin
                  next_st.cfg = defaults(st.cand, def_rate);
               end
            end else begin
               next_st.tmr = st.tmr + 32'h0000_0001;
            end
         end
         default: next_st.fsm = MSI_ST_RUN;
      endcase

      // Mode lamps
      case (st.fsm)
         MSI_ST_ACK: next_st.mode_led = {3{st.flash}};
         MSI_ST_SEL: next_st.mode_led = st.flash ? st.cand : 3'b000;
         default:    next_st.mode_led = st.mode;
      endcase

      next_st.rssi_led = bar(rssi_level > 4'd8 ? 4'd8 : rssi_level);

      if (frame_tx || frame_rx) begin
         next_st.act_cnt = 32'(ACT_CYC);
      end else if (st.act_cnt != 32'h0000_0000) begin
         next_st.act_cnt = st.act_cnt - 32'h0000_0001;
      end
      next_st.act_led = (next_st.act_cnt != 32'h0000_0000);

      if (!supply_ok) begin
         next_st.pwr_led = 1'b0;
      end else if (st.comfail) begin
         next_st.pwr_led = st.flash;
      end else begin
         next_st.pwr_led = 1'b1;
      end

      if (pulse_en) begin
         if (din_rise[0]) next_st.pulse0 = st.pulse0 + 32'h0000_0001;
         if (NCH > 1 && din_rise[NCH > 1 ? 1 : 0]) begin
            next_st.pulse1 = st.pulse1 + 32'h0000_0001;
         end
      end

      if (st.mode != MSI_MODE_FIELDBUS) begin
         next_st.relay = peer_din;
      end

      // Register bus: one-cycle answer after waitrequest drops
      if ((avs_read || avs_write) && !st.ack) begin
         next_st.ack = 1'b1;
         if (avs_write) begin
            case (avs_address)
               `MSI_REG_CTRL: begin
                  next_st.comfail = avs_writedata[`MSI_CTRL_COMFAIL_BIT];
                  if (!SHORT_RANGE) begin
                     next_st.cfg.rate = avs_writedata[`MSI_CTRL_RATE_LSB +: 8];
                  end
               end
               `MSI_REG_CFG: begin
                  next_st.cfg.id    = avs_writedata[`MSI_CFG_ID_LSB +: 8];
                  next_st.cfg.retry = avs_writedata[`MSI_CFG_RETRY_LSB +: 8];
                  next_st.cfg.enc   = avs_writedata[`MSI_CFG_ENC_BIT];
                  next_st.cfg.addr  = avs_writedata[`MSI_CFG_ADDR_LSB +: 8];
               end
               `MSI_REG_AIN0:  next_st.ain0 = avs_writedata[15:0];
               `MSI_REG_AIN1:  next_st.ain1 = avs_writedata[15:0];
               `MSI_REG_AOUT0: next_st.aout0 = avs_writedata[11:0];
               `MSI_REG_AOUT1: next_st.aout1 = avs_writedata[11:0];
               `MSI_REG_RANGE: next_st.range = avs_writedata[7:0];
               `MSI_REG_IO: begin
                  if (st.mode == MSI_MODE_FIELDBUS) begin
                     next_st.relay = avs_writedata[8 +: NCH];
                  end
               end
               default: ;
            endcase
         end
         case (avs_address)
            `MSI_REG_CTRL:   next_st.rdata = {16'h0000, st.cfg.rate, 7'h00, st.comfail};
            `MSI_REG_STATUS: next_st.rdata = {24'h0000_00, 1'b0, st.fsm, st.mode};
            `MSI_REG_CFG:    next_st.rdata = {st.cfg.addr, 7'h00, st.cfg.enc,
                                              st.cfg.retry, st.cfg.id};
            `MSI_REG_RSSI:   next_st.rdata = {24'h0000_00, st.cfg.slave_timeout};
            `MSI_REG_AIN0:   next_st.rdata = {16'h0000, st.ain0};
            `MSI_REG_AIN1:   next_st.rdata = {16'h0000, st.ain1};
            `MSI_REG_AOUT0:  next_st.rdata = {20'h0_0000, st.aout0};
            `MSI_REG_AOUT1:  next_st.rdata = {20'h0_0000, st.aout1};
            `MSI_REG_RANGE:  next_st.rdata = {24'h0000_00, st.range};
            `MSI_REG_PULSE0: next_st.rdata = st.pulse0;
            `MSI_REG_PULSE1: next_st.rdata = st.pulse1;
            `MSI_REG_IO:     next_st.rdata = {16'h0000, 8'(st.relay), 8'(st.din_q)};
            default:         next_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st          <= '0;
         st.fsm      <= MSI_ST_RUN;
         st.mode     <= MSI_MODE_FIELDBUS;
         st.cand     <= MSI_MODE_FIELDBUS;
         st.cfg.id   <= `MSI_DEF_ID;
         st.cfg.retry <= `MSI_DEF_RETRY;
         st.cfg.addr <= `MSI_DEF_ADDR;
         st.cfg.slave_timeout <= `MSI_DEF_TIMEOUT_S;
         st.cfg.rate <= SHORT_RANGE ? `MSI_RATE_FIXED : LONG_RATE;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // Pulse counting takes raw samples, so the 20 kHz limit needs clk well above 40 kHz
   assign avs_readdata    = st.rdata;
   assign avs_waitrequest = ~st.ack;
   assign mode_led        = st.mode_led;
   assign rssi_led        = st.rssi_led;
   assign act_led         = st.act_led;
   assign pwr_led         = st.pwr_led;
   assign din_led         = st.din_q;
   assign relay_led       = st.relay;
   assign relay_out       = st.relay;
   assign peer_dout       = st.din_q;
endmodule

// >>> include/msi_params.svh
`ifndef MSI_PARAMS_SVH
`define MSI_PARAMS_SVH

`define MSI_CLK_HZ          50000000
`define MSI_SEL_TIMEOUT_MS  4000
`define MSI_SEL_TIMEOUT_CYC ((`MSI_CLK_HZ / 1000) * `MSI_SEL_TIMEOUT_MS)
`define MSI_HOLD_MS         2000
`define MSI_HOLD_CYC        ((`MSI_CLK_HZ / 1000) * `MSI_HOLD_MS)
`define MSI_DEB_MS          20
`define MSI_DEB_CYC         ((`MSI_CLK_HZ / 1000) * `MSI_DEB_MS)
`define MSI_FLASH_MS        250
`define MSI_FLASH_CYC       ((`MSI_CLK_HZ / 1000) * `MSI_FLASH_MS)
`define MSI_ACT_MS          50
`define MSI_ACT_CYC         ((`MSI_CLK_HZ / 1000) * `MSI_ACT_MS)
`define MSI_ACK_FLASHES     4

`define MSI_REG_CTRL        8'h00
`define MSI_REG_STATUS      8'h04
`define MSI_REG_CFG         8'h08
`define MSI_REG_RSSI        8'h0C
`define MSI_REG_AIN0        8'h10
`define MSI_REG_AIN1        8'h14
`define MSI_REG_AOUT0       8'h18
`define MSI_REG_AOUT1       8'h1C
`define MSI_REG_RANGE       8'h20
`define MSI_REG_PULSE0      8'h24
`define MSI_REG_PULSE1      8'h28
`define MSI_REG_IO          8'h2C

`define MSI_CTRL_COMFAIL_BIT 0
`define MSI_CTRL_RATE_LSB    8
`define MSI_CFG_ID_LSB       0
`define MSI_CFG_RETRY_LSB    8
`define MSI_CFG_ENC_BIT      16
`define MSI_CFG_ADDR_LSB     24

`define MSI_DEF_ID          8'h11
`define MSI_DEF_RETRY       8'd10
`define MSI_DEF_ADDR        8'd1
`define MSI_DEF_TIMEOUT_S   8'd30
`define MSI_RATE_FIXED      8'h00

`endif

// >>> include/msi_pkg.sv
package msi_pkg;
   typedef enum logic [2:0] {
      MSI_MODE_FIELDBUS = 3'b001,
      MSI_MODE_PEER_MST = 3'b010,
      MSI_MODE_PEER_SLV = 3'b100
   } msi_mode_e;

   typedef enum logic [3:0] {
      MSI_ST_RUN  = 4'b0001,
      MSI_ST_HOLD = 4'b0010,
      MSI_ST_ACK  = 4'b0100,
      MSI_ST_SEL  = 4'b1000
   } msi_state_e;

   typedef struct packed {
      logic [7:0] id;
      logic [7:0] retry;
      logic       enc;
      logic [7:0] addr;
      logic [7:0] slave_timeout;
      logic [7:0] rate;
   } msi_cfg_s;
endpackage

// >>> include/msi_btn_if.sv
`timescale 1ns/1ns
interface msi_btn_if;
   logic level;
   logic press;
   logic release_ev;
   modport src (output level, output press, output release_ev);
   modport dst (input level, input press, input release_ev);
endinterface

// >>> verilog/msi_debounce.sv
`timescale 1ns/1ns
`include "msi_params.svh"
module msi_debounce
   import msi_pkg::*;
#(
   parameter int DEB_CYC = `MSI_DEB_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic ce,
   // Raw button, high while pressed
   input  wire logic btn_raw,
   // Clean events
   msi_btn_if.src    btn
);
   initial begin
      if (DEB_CYC < 1) $error("DEB_CYC must be at least 1");
   end

   typedef struct packed {
      logic        level;
      logic        press;
      logic        rel;
      logic [31:0] cnt;
   } msi_deb_s;

   msi_deb_s st;
   msi_deb_s next_st;

   always_comb begin
      next_st       = st;
      next_st.press = 1'b0;
      next_st.rel   = 1'b0;
      if (btn_raw == st.level) begin
         next_st.cnt = 32'h0000_0000;
      end else if (st.cnt >= 32'(DEB_CYC - 1)) begin
         next_st.cnt   = 32'h0000_0000;
         next_st.level = btn_raw;
         next_st.press = btn_raw;
         next_st.rel   = ~btn_raw;
      end else begin
         next_st.cnt = st.cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign btn.level      = st.level;
   assign btn.press      = st.press;
   assign btn.release_ev = st.rel;
endmodule

// >>> tb/msi_op_model.sv
`timescale 1ns/1ns
module msi_op_model (
   // Clock
   input  wire logic clk,
   // Button, high while pressed
   output logic      btn_raw
);
   initial btn_raw = 1'b0;
   // Chatter first, one cycle only, so it must not count as a press
   task automatic push(input int n);
      @(posedge clk) btn_raw <= 1'b1;
      @(posedge clk) btn_raw <= 1'b0;
      @(posedge clk) btn_raw <= 1'b1;
      repeat (n) @(posedge clk);
      btn_raw <= 1'b0;
   endtask
   task automatic hold_on();
      @(posedge clk) btn_raw <= 1'b1;
   endtask
   task automatic let_go();
      @(posedge clk) btn_raw <= 1'b0;
   endtask
endmodule

// >>> tb/msi_ctrl_sva.sv
`timescale 1ns/1ns
module msi_ctrl_sva
   import msi_pkg::*;
#(
   parameter int NCH = 2
) (
   // Clock and reset
   input wire logic           clk,
   input wire logic           nrst,
   input wire logic           ce,
   // Register bus
   input wire logic [7:0]     avs_address,
   input wire logic           avs_read,
   input wire logic           avs_write,
   input wire logic [31:0]    avs_readdata,
   input wire logic           avs_waitrequest,
   // Panel
   input wire logic           frame_tx,
   input wire logic           frame_rx,
   input wire logic [3:0]     rssi_level,
   input wire logic [NCH-1:0] din,
   input wire logic [NCH-1:0] peer_din,
   input wire logic [2:0]     mode_led,
   input wire logic [7:0]     rssi_led,
   input wire logic           act_led,
   input wire logic [NCH-1:0] din_led,
   input wire logic [NCH-1:0] relay_led,
   input wire logic [NCH-1:0] relay_out,
   input wire logic [NCH-1:0] peer_dout
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   wire logic req = (avs_read || avs_write) && avs_waitrequest;
   function automatic logic [7:0] bar(input logic [3:0] l);
      return (l > 4'h8) ? 8'hFF : 8'((9'h001 << l) - 9'h001);
   endfunction
   property p_ans; req |=> !avs_waitrequest; endproperty
   a_ans: assert property (p_ans) else $error("no answer after request");
   property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_one: assert property (p_one) else $error("answer longer than one cycle");
   property p_unmap; req && avs_read && avs_address == 8'hFC |=> avs_readdata == 32'h0000_0000;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_rate; req && avs_read && avs_address == 8'h00 |=> avs_readdata[15:8] == 8'h00;
   endproperty
   a_rate: assert property (p_rate) else $error("rate field not fixed");
   // Frozen state keeps the old bar, so only enabled cycles count
   sequence s_rssi_still; ($stable(rssi_level) && ce)[*3]; endsequence
   property p_bar; s_rssi_still |-> rssi_led == bar(rssi_level); endproperty
   a_bar: assert property (p_bar) else $error("signal bar wrong");
   property p_act; frame_tx || frame_rx |-> ##[1:2] act_led; endproperty
   a_act: assert property (p_act) else $error("activity lamp missed frame");
   // Eight steady samples rule out a flashing candidate lamp
   sequence s_peer; ((mode_led == 3'b010 || mode_led == 3'b100) && $stable(peer_din)
      && $stable(din))[*8]; endsequence
   property p_peer; s_peer |-> relay_out == peer_din && peer_dout == din; endproperty
   a_peer: assert property (p_peer) else $error("peer mapping wrong");
   property p_din; $stable(din)[*3] |-> din_led == din; endproperty
   a_din: assert property (p_din) else $error("input lamp wrong");
   property p_relay; $stable(relay_out)[*3] |-> relay_led == relay_out; endproperty
   a_relay: assert property (p_relay) else $error("relay lamp wrong");
   property p_legal; mode_led inside {3'b000, 3'b001, 3'b010, 3'b100, 3'b111}; endproperty
   a_legal: assert property (p_legal) else $error("mode lamps illegal");
   // Repetition matches the bench's flash half-period of four
   sequence s_ack_on; $rose(mode_led == 3'b111); endsequence
   property p_ack; s_ack_on |-> (mode_led == 3'b111)[*4] ##1 mode_led == 3'b000; endproperty
   a_ack: assert property (p_ack) else $error("all-lamp flash wrong");
endmodule
bind msi_ctrl msi_ctrl_sva #(.NCH(NCH)) u_sva (
   .clk(clk), .nrst(nrst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .frame_tx(frame_tx), .frame_rx(frame_rx), .rssi_level(rssi_level), .din(din),
   .peer_din(peer_din), .mode_led(mode_led), .rssi_led(rssi_led), .act_led(act_led),
   .din_led(din_led), .relay_led(relay_led), .relay_out(relay_out), .peer_dout(peer_dout)
);

// >>> tb/msi_ctrl_tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module msi_ctrl_tb;
   localparam int  NCH = 2;
   logic           clk, nrst, ce, btn_raw, supply_ok, frame_tx, frame_rx;
   logic           avs_read, avs_write, avs_waitrequest, act_led, pwr_led, po, pa;
   logic [7:0]     avs_address, rssi_led;
   logic [31:0]    avs_writedata, avs_readdata, q;
   logic [3:0]     rssi_level;
   logic [2:0]     mode_led, lo, la;
   logic [NCH-1:0] din, peer_din, din_led, relay_led, relay_out, peer_dout;
   int             n_errors, tests_run;
   msi_ctrl #(.NCH(NCH), .SEL_TIMEOUT(40), .HOLD_CYC(20), .DEB_CYC(2), .FLASH_CYC(4),
      .ACT_CYC(3)) dut (
      .clk(clk), .nrst(nrst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .btn_raw(btn_raw), .supply_ok(supply_ok),
      .frame_tx(frame_tx), .frame_rx(frame_rx), .rssi_level(rssi_level), .din(din),
      .peer_din(peer_din), .mode_led(mode_led), .rssi_led(rssi_led), .act_led(act_led),
      .pwr_led(pwr_led), .din_led(din_led), .relay_led(relay_led), .relay_out(relay_out),
      .peer_dout(peer_dout));
   msi_op_model u_op (.clk(clk), .btn_raw(btn_raw));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      repeat (6000) @(posedge clk);
      n_errors++;
      conclude();
   end
   task automatic conclude();
      if (n_errors == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !w;
      avs_write <= w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      `CHK("waitrequest", 1'b0, avs_waitrequest)
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic obs(input int n);
      lo = 3'b000;
      la = 3'b111;
      po = 1'b0;
      pa = 1'b1;
      repeat (n) begin
         @(negedge clk);
         lo |= mode_led;
         la &= mode_led;
         po |= pwr_led;
         pa &= pwr_led;
      end
   endtask
   task automatic t_regs();
      bus(1'b0, 8'hFC, 32'h0000_0000);
      `CHK("unmapped", 32'h0000_0000, q)
      bus(1'b1, 8'h00, 32'h0000_5500);
      bus(1'b0, 8'h00, 32'h0000_0000);
      `CHK("rate", 8'h00, q[15:8])
      bus(1'b1, 8'h18, 32'h0000_FFFF);
      bus(1'b0, 8'h18, 32'h0000_0000);
      `CHK("aout", 32'h0000_0FFF, q)
      bus(1'b1, 8'h00, 32'h0000_0001);
      obs(24);
      `CHK("pwr flash", 2'b10, {po, pa})
      bus(1'b1, 8'h00, 32'h0000_0000);
      repeat (4) @(posedge clk);
      obs(12);
      `CHK("pwr steady", 2'b11, {po, pa})
      @(posedge clk) supply_ok <= 1'b0;
      repeat (4) @(posedge clk);
      obs(8);
      `CHK("pwr off", 2'b00, {po, pa})
      @(posedge clk) supply_ok <= 1'b1;
   endtask
   task automatic t_rssi();
      logic [7:0] e;
      for (int i = 0; i <= 9; i++) begin
         @(posedge clk) rssi_level <= (i == 9) ? 4'hF : 4'(i);
         e = (i >= 8) ? 8'hFF : 8'((9'h001 << i) - 9'h001);
         repeat (5) @(negedge clk);
         `CHK("bar", e, rssi_led)
      end
      @(posedge clk);
      ce <= 1'b0;
      rssi_level <= 4'h0;
      repeat (5) @(negedge clk);
      `CHK("frozen", 8'hFF, rssi_led)
      @(posedge clk) ce <= 1'b1;
      repeat (3) @(negedge clk);
      `CHK("thawed", 8'h00, rssi_led)
   endtask
   task automatic t_act();
      int n;
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         frame_tx <= (k == 0);
         frame_rx <= (k == 1);
         @(posedge clk);
         frame_tx <= 1'b0;
         frame_rx <= 1'b0;
         n = 0;
         while (act_led !== 1'b1 && n < 5) begin
            @(negedge clk);
            n++;
         end
         `CHK("act on", 1'b1, act_led)
         repeat (10) @(negedge clk);
         `CHK("act off", 1'b0, act_led)
      end
   endtask
   task automatic t_io();
      @(posedge clk) din <= 2'b01;
      bus(1'b1, 8'h2C, 32'h0000_0200);
      repeat (6) @(negedge clk);
      `CHK("lamps", 6'b01_10_10, {din_led, relay_out, relay_led})
      bus(1'b0, 8'h2C, 32'h0000_0000);
      `CHK("io", 32'h0000_0201, q)
      bus(1'b0, 8'h24, 32'h0000_0000);
      `CHK("pulse", 32'h0000_0001, q)
   endtask
   task automatic t_short();
      u_op.push(8);
      repeat (30) @(posedge clk);
      obs(10);
      `CHK("short", 6'b001_001, {lo, la})
   endtask
   task automatic sel(input logic [2:0] cur, input logic [2:0] nxt);
      int n;
      u_op.hold_on();
      n = 0;
      while (mode_led !== 3'b111 && n < 200) begin
         @(negedge clk);
         n++;
      end
      `CHK("ack", 3'b111, mode_led)
      u_op.let_go();
      // Acknowledge takes four flashes of eight cycles
      repeat (36) @(posedge clk);
      obs(16);
      `CHK("cand", cur, lo)
      u_op.push(8);
      repeat (4) @(posedge clk);
      obs(16);
      `CHK("next", nxt, lo)
      repeat (60) @(posedge clk);
      obs(10);
      `CHK("mode", {nxt, nxt}, {lo, la})
      bus(1'b0, 8'h08, 32'h0000_0000);
      `CHK("cfg", 32'h0100_0A11, q)
   endtask
   task automatic t_mode();
      bus(1'b1, 8'h08, 32'h0300_0122);
      sel(3'b001, 3'b010);
      bus(1'b0, 8'h0C, 32'h0000_0000);
      `CHK("tmo master", 32'h0000_0000, q)
      peer_din <= 2'b10;
      din <= 2'b01;
      // Relay writes must be refused while peered
      bus(1'b1, 8'h2C, 32'h0000_0100);
      repeat (6) @(negedge clk);
      `CHK("peer", 4'b10_01, {relay_out, peer_dout})
      sel(3'b010, 3'b100);
      bus(1'b0, 8'h0C, 32'h0000_0000);
      `CHK("tmo slave", 32'h0000_001E, q)
      sel(3'b100, 3'b001);
   endtask
   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      supply_ok = 1'b1;
      frame_tx = 1'b0;
      frame_rx = 1'b0;
      rssi_level = 4'h0;
      din = '0;
      peer_din = '0;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      n_errors = 0;
      tests_run = 0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(negedge clk);
      `CHK("reset", 4'b001_1, {mode_led, avs_waitrequest})
      t_regs();
      t_rssi();
      t_act();
      t_io();
      t_short();
      t_mode();
      conclude();
   end
endmodule
